/* File: src/rx_status_word.v */
// receive status word builder, receiver halt/restart and receive error flag
// assumes an internal nibble receive path and fifo event pulses on clock_in,
// and an apb master on the same clock
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "rx_status_defs.vh"

module rx_status_word (
  // clock, reset, enable
  input  wire        clock_in,
  input  wire        reset_n_in,
  input  wire        clk_en_in,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output wire        pready_out,
  output reg  [31:0] prdata_out,
  output reg         pslverr_out,
  // internal receive path
  input  wire        rx_dv_in,
  input  wire        rx_er_in,
  input  wire        rx_nibble_valid_in,
  input  wire [3:0]  rxd_in,
  input  wire        collision_in,
  // fifo events
  input  wire        data_underrun_in,
  input  wire        status_underrun_in,
  input  wire        status_overrun_in,
  // status out
  output reg  [31:0] status_word_out,
  output reg         status_valid_out,
  output reg         frame_drop_out,
  output wire        receiver_halted_event_out,
  output wire        receive_error_flag_out,
  output wire        receiver_on_bit_out
);

  // control word
  reg         receiver_on_bit_reg;
  reg         pass_bad_reg;
  reg  [31:0] last_status_reg;

  // receive engine
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [14:0] nib_reg;
  reg  [14:0] nib_next;
  reg  [15:0] type_reg;
  reg  [15:0] type_next;
  reg         mcast_reg;
  reg         mcast_next;
  reg         late_reg;
  reg         late_next;
  reg         miierr_reg;
  reg         miierr_next;
  reg         halted_pulse_reg;
  reg         finish;
  reg         take;

  wire [31:0] crc_value;
  wire [13:0] bytes_now = nib_reg[14:1];

  // apb decode
  // unmapped offsets answer with an error and read as zero
  wire        apb_setup = psel_in & ~penable_in;
  wire        apb_write = psel_in & penable_in & pwrite_in;
  wire        hit_ctl   = (paddr_in == `OFS_MAC_CONTROL);
  wire        hit_sta   = (paddr_in == `OFS_RX_STATE);
  wire        hit_last  = (paddr_in == `OFS_LAST_STATUS);
  wire        hit_any   = hit_ctl | hit_sta | hit_last;

  // zero wait states; read data is staged in the setup cycle
  assign pready_out = 1'b1;

  // register writes
  // clk_en low holds every register, so a write needs it high too
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      receiver_on_bit_reg <= 1'b0;
      pass_bad_reg        <= 1'b0;
    end else if (clk_en_in && apb_write && hit_ctl) begin
      receiver_on_bit_reg <= pwdata_in[`CTL_RX_ON_BIT];
      pass_bad_reg        <= pwdata_in[`CTL_PASS_BAD_BIT];
    end
  end

  assign receiver_on_bit_out = receiver_on_bit_reg;

  // write one to the error bit clears it
  wire err_clear = apb_write & hit_sta & pwdata_in[`STA_ERROR_BIT];
  wire err_set   = data_underrun_in | status_underrun_in | status_overrun_in;

  // the flag does not touch the receive engine at all
  sticky_flag u_err_flag (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .set_in     (err_set),
    .clear_in   (err_clear),
    .flag_out   (receive_error_flag_out)
  );

  // register reads
  // staged at setup so prdata comes straight from a flop in the access phase
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      prdata_out  <= 32'h00000000;
      pslverr_out <= 1'b0;
    end else if (clk_en_in && apb_setup) begin
      pslverr_out <= ~hit_any;
      prdata_out  <= 32'h00000000;
      if (!pwrite_in) begin
        if (hit_ctl) begin
          prdata_out[`CTL_RX_ON_BIT]    <= receiver_on_bit_reg;
          prdata_out[`CTL_PASS_BAD_BIT] <= pass_bad_reg;
        end
        if (hit_sta) begin
          prdata_out[`STA_HALTED_BIT] <= (state_reg == `RS_HALT);
          prdata_out[`STA_ERROR_BIT]  <= receive_error_flag_out;
        end
        if (hit_last)
          prdata_out <= last_status_reg;
      end
    end
  end

  // crc over the whole frame including the fcs
  // checking the residue avoids holding the last four bytes back
  crc32_nibble u_crc (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .init_in    (state_reg != `RS_RECV),
    .valid_in   (take),
    .nibble_in  (rxd_in),
    .crc_out    (crc_value)
  );

  // receive engine
  // one nibble a strobe; the byte count is the nibble count halved
  always @* begin
    state_next  = state_reg;
    nib_next    = nib_reg;
    type_next   = type_reg;
    mcast_next  = mcast_reg;
    late_next   = late_reg;
    miierr_next = miierr_reg;
    finish      = 1'b0;
    take        = 1'b0;
    case (state_reg)
      `RS_HALT: begin
        // a frame already on the wire at restart is skipped whole
        if (receiver_on_bit_reg)
          state_next = rx_dv_in ? `RS_DRAIN : `RS_IDLE;
      end
      `RS_IDLE: begin
        nib_next    = 15'h0000;
        type_next   = 16'h0000;
        mcast_next  = 1'b0;
        late_next   = 1'b0;
        miierr_next = 1'b0;
        if (!receiver_on_bit_reg) begin
          state_next = `RS_HALT;
        end else if (rx_dv_in) begin
          state_next  = `RS_RECV;
          miierr_next = rx_er_in;
          if (rx_nibble_valid_in) begin
            take       = 1'b1;
            nib_next   = 15'h0001;
            mcast_next = rxd_in[0];
          end
        end
      end
      `RS_RECV: begin
        if (!rx_dv_in) begin
          finish     = 1'b1;
          state_next = receiver_on_bit_reg ? `RS_IDLE : `RS_HALT;
        end else begin
          if (rx_er_in)
            miierr_next = 1'b1;
          // a collision inside the window is an ordinary one, not reported
          if (collision_in && bytes_now >= `COLL_WINDOW_BYTES)
            late_next = 1'b1;
          if (rx_nibble_valid_in) begin
            take     = 1'b1;
            nib_next = nib_reg + 15'h0001;
            if (nib_reg == 15'h0000)
              mcast_next = rxd_in[0];
            // length/type field arrives high byte first, low nibble first
            case (nib_reg)
              `TYPE_NIB_HI_LO: type_next[11:8]  = rxd_in;
              `TYPE_NIB_HI_HI: type_next[15:12] = rxd_in;
              `TYPE_NIB_LO_LO: type_next[3:0]   = rxd_in;
              `TYPE_NIB_LO_HI: type_next[7:4]   = rxd_in;
              default:  type_next        = type_reg;
            endcase
            // the watchdog cuts the frame off; the rest is skipped
            if (nib_next[14:1] >= `CUTOFF_BYTES) begin
              finish     = 1'b1;
              state_next = `RS_DRAIN;
            end
          end
        end
      end
      `RS_DRAIN: begin
        // skipped bytes are neither counted nor checked
        if (!rx_dv_in)
          state_next = receiver_on_bit_reg ? `RS_IDLE : `RS_HALT;
      end
      default: state_next = `RS_HALT;
    endcase
  end

  // status fields of the frame being finished; finish uses the next values
  wire [13:0] f_bytes   = nib_next[14:1];
  wire        f_runt    = f_bytes < `COLL_WINDOW_BYTES;
  wire        f_long    = f_bytes > `MAX_FRAME_BYTES;
  wire        f_wdog    = f_bytes > `WDOG_BYTES;
  wire        f_type    = (f_bytes >= `TYPE_MIN_BYTES) && (type_next > `TYPE_LEN_LIMIT);
  wire        f_dribble = nib_next[0] & ~late_next;
  wire        f_crc     = (crc_value != `CRC_RESIDUE) | miierr_next;

  reg  [31:0] word;

  always @* begin
    word                                = 32'h00000000;
    word[`ST_LEN_HI:`ST_LEN_LO]         = f_bytes;
    word[`ST_RUNT_BIT]                  = f_runt;
    word[`ST_MCAST_BIT]                 = mcast_next;
    word[`ST_LONG_BIT]                  = f_long;
    word[`ST_LATECOL_BIT]               = late_next;
    word[`ST_TYPE_BIT]                  = f_type;
    word[`ST_WDOG_BIT]                  = f_wdog;
    word[`ST_MIIERR_BIT]                = miierr_next;
    word[`ST_DRIBBLE_BIT]               = f_dribble;
    // left raw for runt, late and watchdog frames; host ignores it
    word[`ST_CRC_BIT]                   = f_crc;
    word[`ST_SUMMARY_BIT]               = f_runt | f_long | late_next | f_crc;
  end

  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      state_reg        <= `RS_HALT;
      nib_reg          <= 15'h0000;
      type_reg         <= 16'h0000;
      mcast_reg        <= 1'b0;
      late_reg         <= 1'b0;
      miierr_reg       <= 1'b0;
      halted_pulse_reg <= 1'b0;
      status_word_out  <= 32'h00000000;
      status_valid_out <= 1'b0;
      frame_drop_out   <= 1'b0;
      last_status_reg  <= 32'h00000000;
    end else if (clk_en_in) begin
      state_reg  <= state_next;
      nib_reg    <= nib_next;
      type_reg   <= type_next;
      mcast_reg  <= mcast_next;
      late_reg   <= late_next;
      miierr_reg <= miierr_next;
      // only the halt entry from a running receiver pulses, once
      halted_pulse_reg <= (state_reg != `RS_HALT) && (state_next == `RS_HALT);
      // pulses fall by default so each lasts exactly one enabled cycle; clk_en low holds them high
      status_valid_out <= 1'b0;
      frame_drop_out   <= 1'b0;
      // a dropped runt still updates the word so the host can see why
      if (finish) begin
        status_word_out <= word;
        last_status_reg <= word;
        if (f_runt && !pass_bad_reg)
          frame_drop_out <= 1'b1;
        else
          status_valid_out <= 1'b1;
      end
    end
  end

  assign receiver_halted_event_out = halted_pulse_reg & clk_en_in;

endmodule // rx_status_word

/* File: src/rx_status_defs.vh */
// constants for the receive status word and stop logic
// assumes a 20 MHz system clock and a nibble-wide internal receive path
`ifndef RX_STATUS_DEFS_VH
`define RX_STATUS_DEFS_VH

// status word bit positions
`define ST_LEN_HI        29
`define ST_LEN_LO        16
`define ST_SUMMARY_BIT   15
`define ST_RUNT_BIT      11
`define ST_MCAST_BIT     10
`define ST_LONG_BIT      7
`define ST_LATECOL_BIT   6
`define ST_TYPE_BIT      5
`define ST_WDOG_BIT      4
`define ST_MIIERR_BIT    3
`define ST_DRIBBLE_BIT   2
`define ST_CRC_BIT       1

// frame size limits in bytes
`define COLL_WINDOW_BYTES 14'h0040
`define MAX_FRAME_BYTES   14'h05ee
`define TYPE_LEN_LIMIT    16'h05dc
`define TYPE_MIN_BYTES    14'h000e
`define WDOG_BYTES        14'h0800
`define CUTOFF_BYTES      14'h0a00

// nibble index of the length/type field, high byte first on the wire
`define TYPE_NIB_HI_LO    15'h0018
`define TYPE_NIB_HI_HI    15'h0019
`define TYPE_NIB_LO_LO    15'h001a
`define TYPE_NIB_LO_HI    15'h001b

// crc32 constants, reflected form
`define CRC_INIT          32'hffffffff
`define CRC_POLY          32'hedb88320
`define CRC_RESIDUE       32'hdebb20e3

// register byte offsets
`define OFS_MAC_CONTROL   12'h000
`define OFS_RX_STATE      12'h004
`define OFS_LAST_STATUS   12'h008

// field positions
`define CTL_RX_ON_BIT     0
`define CTL_PASS_BAD_BIT  16
`define STA_HALTED_BIT    0
`define STA_ERROR_BIT     1

// receive engine states
`define RS_HALT           2'h0
`define RS_IDLE           2'h1
`define RS_RECV           2'h2
`define RS_DRAIN          2'h3

`endif

/* File: src/crc32_nibble.v */
// running crc32 over a nibble stream, low nibble of each byte first
// assumes nibbles arrive from logic on the same clock
`timescale 1ns/1ps
`include "rx_status_defs.vh"

module crc32_nibble (
  // clock and reset
  input  wire        clock_in,
  input  wire        reset_n_in,
  input  wire        clk_en_in,
  // nibble stream
  input  wire        init_in,
  input  wire        valid_in,
  input  wire [3:0]  nibble_in,
  // result
  output reg  [31:0] crc_out
);

  reg [31:0] seed;
  reg [31:0] crc_next;
  integer    i;

  always @* begin
    seed     = init_in ? `CRC_INIT : crc_out;
    crc_next = seed;
    if (valid_in) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (crc_next[0] ^ nibble_in[i])
          crc_next = (crc_next >> 1) ^ `CRC_POLY;
        else
          crc_next = crc_next >> 1;
      end
    end
  end

  always @(posedge clock_in) begin
    if (!reset_n_in)
      crc_out <= `CRC_INIT;
    else if (clk_en_in)
      crc_out <= crc_next;
  end

endmodule // crc32_nibble

/* File: src/sticky_flag.v */
// sticky flag set by hardware and cleared by software
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ps

module sticky_flag (
  // clock and reset
  input  wire clock_in,
  input  wire reset_n_in,
  input  wire clk_en_in,
  // control
  input  wire set_in,
  input  wire clear_in,
  // state
  output reg  flag_out
);

  // a set in the clearing cycle wins
  wire flag_next = set_in | (flag_out & ~clear_in);

  always @(posedge clock_in) begin
    if (!reset_n_in)
      flag_out <= 1'b0;
    else if (clk_en_in)
      flag_out <= flag_next;
  end

endmodule // sticky_flag

/* File: verif/rx_status_word_chk.sv */
// assertion checker for the receive status word block
// assumes one clock domain with synchronous active-low reset
`timescale 1ns/1ps
module rx_status_word_chk (
  // clock and reset
  input wire        clock_in,
  input wire        reset_n_in,
  input wire        clk_en_in,
  // apb and fifo events
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire        data_underrun_in,
  input wire        status_underrun_in,
  input wire        status_overrun_in,
  // watched outputs
  input wire [31:0] status_word_out,
  input wire        status_valid_out,
  input wire        frame_drop_out,
  input wire        receiver_halted_event_out,
  input wire        receive_error_flag_out,
  input wire        receiver_on_bit_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  wire [31:0] sw  = status_word_out;
  wire [13:0] len = sw[29:16];
  // a one-to-clear write is the only legal way down for the flag
  wire        clr = psel_in && penable_in && pwrite_in && paddr_in == 12'h004 && pwdata_in[1];
  wire        ev  = data_underrun_in || status_underrun_in || status_overrun_in;

  a_reserved_zero: assert property (sw[9:8] == 2'b00 && !sw[0]) else $error("reserved set");
  a_summary_or: assert property (sw[15] == (sw[11] | sw[7] | sw[6] | sw[1]))
    else $error("summary bit wrong");
  a_dribble_late: assert property (sw[6] |-> !sw[2]) else $error("dribble with late");
  a_long_len: assert property (sw[7] == (len > 14'd1518)) else $error("too-long wrong");
  a_wdog_len: assert property (sw[4] |-> len > 14'd2048) else $error("watchdog wrong");
  a_type_runt: assert property (sw[5] |-> len >= 14'd14) else $error("type on short");
  a_runt_len: assert property (sw[11] |-> len < 14'd64) else $error("runt wrong");
  a_drop_runt: assert property (frame_drop_out |-> sw[11] && !status_valid_out)
    else $error("drop of non-runt");
  a_halt_once: assert property (receiver_halted_event_out |=> !receiver_halted_event_out)
    else $error("halt pulse long");
  a_halt_off: assert property (receiver_halted_event_out |-> !receiver_on_bit_out)
    else $error("halt while on");
  a_err_raise: assert property (ev && clk_en_in |=> receive_error_flag_out)
    else $error("flag not raised");
  a_err_hold: assert property (receive_error_flag_out && !clr |=> receive_error_flag_out)
    else $error("flag dropped");
  c_valid: cover property (status_valid_out);
  c_drop: cover property (frame_drop_out);
  c_halt: cover property (receiver_halted_event_out);
endmodule // rx_status_word_chk

bind rx_status_word rx_status_word_chk u_chk (.clock_in(clock_in), .reset_n_in(reset_n_in),
  .clk_en_in(clk_en_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .data_underrun_in(data_underrun_in),
  .status_underrun_in(status_underrun_in), .status_overrun_in(status_overrun_in),
  .status_word_out(status_word_out), .status_valid_out(status_valid_out),
  .frame_drop_out(frame_drop_out), .receiver_halted_event_out(receiver_halted_event_out),
  .receive_error_flag_out(receive_error_flag_out), .receiver_on_bit_out(receiver_on_bit_out));

/* File: verif/rx_frame_src.sv */
// frame source standing in for the internal receive path
// assumes the bench fills mem and nibbles, then pulses start_in
`timescale 1ns/1ps
module rx_frame_src (
  // clock and control
  input  wire       clock_in,
  input  wire       start_in,
  // receive path
  output reg        rx_dv_out = 0,
  output reg        rx_er_out = 0,
  output reg        strobe_out = 0,
  output reg  [3:0] rxd_out = 4'h0,
  output reg        collision_out = 0
);
  reg [7:0] mem [0:2599];
  int       nibbles = 0;
  int       er_at = -1;
  int       col_at = -1;
  int       n = 0;

  always @(posedge clock_in) begin
    if (start_in || (rx_dv_out && n < nibbles)) begin
      rx_dv_out <= 1'b1;
      strobe_out <= 1'b1;
      rxd_out <= n[0] ? mem[n / 2][7:4] : mem[n / 2][3:0];
      rx_er_out <= (n == er_at);
      collision_out <= (n == col_at);
      n <= n + 1;
    end else begin
      rx_dv_out <= 1'b0;
      strobe_out <= 1'b0;
      rx_er_out <= 1'b0;
      collision_out <= 1'b0;
      // idle line toggles so a stale nibble is never mistaken for data
      rxd_out <= ~rxd_out;
      n <= 0;
    end
  end
endmodule // rx_frame_src

/* File: verif/testbench.sv */
// self-checking bench for the receive status word block
// assumes the frame source drives the receive path on clock_in
`timescale 1ns/1ps
module testbench;
  reg          clock_in = 0;
  reg          reset_n_in = 0;
  reg          clk_en = 1;
  reg          psel = 0;
  reg          penable = 0;
  reg          pwrite = 0;
  reg   [11:0] paddr = 0;
  reg   [31:0] pwdata = 0;
  reg          start = 0;
  reg   [2:0]  fifo_ev = 0;
  wire         pready, pslverr, sv, drop, halted, eflag, on, dv, er, stb, col;
  wire  [31:0] prdata, sw;
  wire  [3:0]  rxd;
  logic [31:0] q, s, x;
  logic        e, d;
  int          bad_count = 0;
  int          num_checks = 0;
  int          i, v, p;

  rx_frame_src u_src (.clock_in(clock_in), .start_in(start), .rx_dv_out(dv), .rx_er_out(er),
    .strobe_out(stb), .rxd_out(rxd), .collision_out(col));
  rx_status_word u_dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
    .rx_dv_in(dv), .rx_er_in(er), .rx_nibble_valid_in(stb), .rxd_in(rxd), .collision_in(col),
    .data_underrun_in(fifo_ev[2]), .status_underrun_in(fifo_ev[1]),
    .status_overrun_in(fifo_ev[0]), .status_word_out(sw), .status_valid_out(sv),
    .frame_drop_out(drop), .receiver_halted_event_out(halted),
    .receive_error_flag_out(eflag), .receiver_on_bit_out(on));

  initial forever #25 clock_in = ~clock_in;

  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // idle edge after release so the next setup never lands in the same step
  task apb(input bit w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock_in);
    penable <= 1;
    i = 0;
    do begin
      @(posedge clock_in);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      bad_count++;
      finish_test;
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock_in);
  endtask

  task fill(input int len, input logic [7:0] b0, input logic [15:0] typ, input bit bad);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int k = 0; k < len - 4; k++) begin
      u_src.mem[k] = k == 0 ? b0 : k == 12 ? typ[15:8] : k == 13 ? typ[7:0] : k[7:0];
      c = c ^ u_src.mem[k];
      for (int b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    c = ~c ^ {31'h0, bad};
    for (int k = 0; k < 4; k++)
      u_src.mem[len - 4 + k] = c[8 * k +: 8];
  endtask

  task send(input int bytes, input int odd);
    u_src.nibbles = 2 * bytes + odd;
    start <= 1;
    @(posedge clock_in);
    start <= 0;
    i = 0;
    do begin
      @(posedge clock_in);
      i++;
    end while (sv !== 1'b1 && drop !== 1'b1 && i < 6000);
    if (sv !== 1'b1 && drop !== 1'b1) begin
      bad_count++;
      finish_test;
    end
    s = sw;
    d = drop;
    @(posedge clock_in);
  endtask

  function logic [31:0] word(input int len, input logic [11:0] low);
    word = {2'b00, len[13:0], low[11] | low[7] | low[6] | low[1], 3'b000, low};
  endfunction

  task t_good_bad;
    for (v = 0; v < 3; v++) begin
      fill(68, 8'h01, 16'h0800, v == 2);
      u_src.er_at = v == 1 ? 40 : -1;
      send(68, 0);
      x = word(68, v == 1 ? 12'h42a : v == 2 ? 12'h422 : 12'h420);
      check("status", x, s);
      apb(0, 12'h008, 32'h0);
      check("last status", x, q);
      check("pass", 0, d);
    end
    u_src.er_at = -1;
    $display("t_good_bad done");
  endtask

  task t_runt;
    fill(20, 8'h00, 16'h0800, 0);
    send(20, 0);
    check("runt drop", 1, d);
    check("runt", word(20, 12'h820) & ~32'h2, s & ~32'h2);
    apb(1, 12'h000, 32'h00010001);
    apb(0, 12'h000, 32'h0);
    check("control", 32'h00010001, q);
    send(20, 0);
    check("runt pass", 0, d);
    fill(10, 8'h00, 16'h0800, 0);
    send(10, 0);
    check("short runt", word(10, 12'h800) & ~32'h2, s & ~32'h2);
    apb(1, 12'h000, 32'h1);
    $display("t_runt done");
  endtask

  task t_long;
    fill(1600, 8'h02, 16'h0040, 0);
    send(1600, 0);
    check("too long", word(1600, 12'h080), s);
    fill(2100, 8'h02, 16'h0040, 0);
    send(2100, 0);
    check("watchdog", word(2100, 12'h090) & ~32'h2, s & ~32'h2);
    $display("t_long done");
  endtask

  task t_dribble;
    fill(68, 8'h02, 16'h0040, 0);
    send(68, 1);
    check("dribble", word(68, 12'h004) & ~32'h8002, s & ~32'h8002);
    u_src.col_at = 132;
    send(68, 1);
    check("late col", word(68, 12'h040) & ~32'h8002, s & ~32'h8002);
    u_src.col_at = -1;
    $display("t_dribble done");
  endtask

  task t_halt;
    apb(1, 12'h000, 32'h0);
    p = 0;
    for (v = 0; v < 40; v++) begin
      @(posedge clock_in);
      if (halted === 1'b1) p++;
    end
    check("halt pulses", 1, p);
    start <= 1;
    @(posedge clock_in);
    start <= 0;
    p = 0;
    for (v = 0; v < 300; v++) begin
      @(posedge clock_in);
      if (sv !== 1'b0 || drop !== 1'b0) p++;
    end
    check("halted rx", 0, p);
    apb(0, 12'h004, 32'h0);
    check("state", 1, q[0]);
    apb(1, 12'h000, 32'h1);
    check("on bit", 1, on);
    $display("t_halt done");
  endtask

  task t_err;
    for (v = 0; v < 3; v++) begin
      fifo_ev <= 3'b100 >> v;
      @(posedge clock_in);
      fifo_ev <= 3'b000;
      @(posedge clock_in);
      check("error flag", 1, eflag);
      apb(0, 12'h004, 32'h0);
      check("flag read", 1, q[1]);
      fill(68, 8'h01, 16'h0800, 0);
      send(68, 0);
      check("rx on error", word(68, 12'h420), s);
      apb(1, 12'h004, 32'h2);
      check("flag clear", 0, eflag);
    end
    apb(0, 12'h0fc, 32'h0);
    check("unmapped err", 1, e);
    check("unmapped data", 0, q);
    clk_en <= 0;
    fifo_ev <= 3'b001;
    @(posedge clock_in);
    fifo_ev <= 3'b000;
    @(posedge clock_in);
    check("frozen flag", 0, eflag);
    clk_en <= 1;
    fifo_ev <= 3'b100;
    @(posedge clock_in);
    fifo_ev <= 3'b000;
    reset_n_in <= 0;
    repeat (2) @(posedge clock_in);
    reset_n_in <= 1;
    @(posedge clock_in);
    check("flag after reset", 0, eflag);
    check("on after reset", 0, on);
    apb(1, 12'h000, 32'h1);
    $display("t_err done");
  endtask

  initial begin
    repeat (20) @(posedge clock_in);
    reset_n_in <= 1;
    @(posedge clock_in);
    apb(1, 12'h000, 32'h1);
    t_good_bad;
    t_runt;
    t_long;
    t_dribble;
    t_halt;
    t_err;
    finish_test;
  end
endmodule // testbench
